// ===== pkg/swire_map.vh
// timing and command constants for the single-wire bus master
`ifndef SWIRE_MAP_VH
`define SWIRE_MAP_VH
`define CLK_MHZ 100
`define T_RST_US 480
`define T_RST_CYC (`T_RST_US * `CLK_MHZ)
`define T_PRES_WAIT_US 70
`define T_PRES_WAIT_CYC (`T_PRES_WAIT_US * `CLK_MHZ)
`define T_RST_HIGH_US 480
`define T_RST_HIGH_CYC (`T_RST_HIGH_US * `CLK_MHZ)
`define T_SLOT_US 65
`define T_SLOT_CYC (`T_SLOT_US * `CLK_MHZ)
`define T_LOW1_US 2
`define T_LOW1_CYC (`T_LOW1_US * `CLK_MHZ)
`define T_SAMPLE_US 13
`define T_SAMPLE_CYC (`T_SAMPLE_US * `CLK_MHZ)
`define T_REC_US 2
`define T_REC_CYC (`T_REC_US * `CLK_MHZ)
`define CMD_SKIP 8'hCC
`define CMD_CONV_T 8'h44
`define CMD_CONV_V 8'hB4
`define CMD_RECALL 8'hB8
`define CMD_FETCH 8'hBE
`define PAGE_BYTES 4'h9
`define OP_CONV_T 2'h0
`define OP_CONV_V 2'h1
`define OP_RECALL 2'h2
`define OP_FETCH 2'h3
`endif

// ===== rtl/slot_engine.v
// single time slot generator: reset/presence, write bit, read bit
`timescale 1ns/1ps
`default_nettype none
`include "swire_map.vh"
module slot_engine (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // request
  input wire go,
  input wire [1:0] kind,
  input wire wbit,
  output reg done_ff,
  output reg rbit_ff,
  // line
  input wire line_in,
  output reg line_oe_ff
);
  localparam K_RESET = 2'h0;
  localparam K_WRITE = 2'h1;
  localparam K_READ = 2'h2;
  localparam S_IDLE = 2'h0;
  localparam S_RUN = 2'h1;
  localparam S_REC = 2'h2;
  reg [1:0] st_ff;
  reg [1:0] kind_ff;
  reg wbit_ff;
  localparam [31:0] RST_LAST = `T_RST_CYC - 1;
  localparam [31:0] PRES_AT = `T_RST_CYC + `T_PRES_WAIT_CYC;
  localparam [31:0] RESET_LEN = `T_RST_CYC + `T_RST_HIGH_CYC;
  localparam [31:0] SLOT_LEN = `T_SLOT_CYC;
  localparam [31:0] SLOT_LAST = `T_SLOT_CYC - 1;
  localparam [31:0] LOW1_LAST = `T_LOW1_CYC - 1;
  localparam [31:0] SAMPLE_AT = `T_SAMPLE_CYC;
  localparam [31:0] REC_LAST = `T_REC_CYC - 1;
  reg [16:0] cnt_ff;
  reg [16:0] len;
  always @* begin
    case (kind_ff)
      K_RESET: len = RESET_LEN[16:0];
      default: len = SLOT_LEN[16:0];
    endcase
  end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st_ff <= S_IDLE;
      kind_ff <= K_RESET;
      wbit_ff <= 1'b0;
      cnt_ff <= 17'h00000;
      done_ff <= 1'b0;
      rbit_ff <= 1'b0;
      line_oe_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (go) begin
            st_ff <= S_RUN;
            kind_ff <= kind;
            wbit_ff <= wbit;
            cnt_ff <= 17'h00000;
            line_oe_ff <= 1'b1;
          end
        end
        S_RUN: begin
          cnt_ff <= cnt_ff + 17'h00001;
          if (kind_ff == K_RESET) begin
            if (cnt_ff == RST_LAST[16:0])
              line_oe_ff <= 1'b0;
            if (cnt_ff == PRES_AT[16:0])
              rbit_ff <= ~line_in;
          end else if (kind_ff == K_WRITE) begin
            if (wbit_ff && cnt_ff == LOW1_LAST[16:0])
              line_oe_ff <= 1'b0;
            if (!wbit_ff && cnt_ff == SLOT_LAST[16:0])
              line_oe_ff <= 1'b0;
          end else if (kind_ff == K_READ) begin
            if (cnt_ff == LOW1_LAST[16:0])
              line_oe_ff <= 1'b0;
            if (cnt_ff == SAMPLE_AT[16:0])
              rbit_ff <= line_in;
          end
          if (cnt_ff == len - 17'h00001) begin
            line_oe_ff <= 1'b0;
            st_ff <= S_REC;
            cnt_ff <= 17'h00000;
          end
        end
        S_REC: begin
          cnt_ff <= cnt_ff + 17'h00001;
          if (cnt_ff == REC_LAST[16:0]) begin
            st_ff <= S_IDLE;
            done_ff <= 1'b1;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/swire_master.v
// single-wire bus master: sequences reset, skip, command, page and byte reads
`timescale 1ns/1ps
`default_nettype none
`include "swire_map.vh"
module swire_master (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [2:0] cmd_page,
  output reg cmd_ready_ff,
  // results
  output reg byte_valid_ff,
  output reg [7:0] byte_data_ff,
  output reg [3:0] byte_index_ff,
  output reg op_done_ff,
  output reg no_presence_ff,
  // open-drain line
  input wire line_in,
  output reg line_out_ff,
  output reg line_oe_ff
);
  localparam S_IDLE = 3'h0;
  localparam S_RESET = 3'h1;
  localparam S_TX = 3'h2;
  localparam S_RX = 3'h3;
  localparam S_POLL = 3'h4;
  localparam S_END = 3'h5;
  localparam K_RESET = 2'h0;
  localparam K_WRITE = 2'h1;
  localparam K_READ = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  reg line_s1_ff;
  reg line_s2_ff;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      line_s1_ff <= 1'b1;
      line_s2_ff <= 1'b1;
    end else begin
      line_s1_ff <= line_in;
      line_s2_ff <= line_s1_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  reg [2:0] st_ff;
  reg [1:0] op_ff;
  reg [2:0] page_ff;
  reg [1:0] tx_idx_ff;
  reg [2:0] bit_ff;
  reg [7:0] sh_ff;
  reg [3:0] rx_cnt_ff;
  reg go_ff;
  reg [1:0] kind_ff;
  reg busy_ff;
  wire slot_done;
  wire slot_bit;
  wire slot_oe;
  slot_engine slot_engine_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .go(go_ff),
    .kind(kind_ff),
    .wbit(sh_ff[0]),
    .done_ff(slot_done),
    .rbit_ff(slot_bit),
    .line_in(line_s2_ff),
    .line_oe_ff(slot_oe)
  );
  reg [7:0] tx_byte;
  reg [1:0] tx_len;
  always @* begin
    tx_len = 2'h2;
    case (tx_idx_ff)
      2'h0: begin
        case (op_ff)
          `OP_CONV_T: tx_byte = `CMD_CONV_T;
          `OP_CONV_V: tx_byte = `CMD_CONV_V;
          `OP_RECALL: tx_byte = `CMD_RECALL;
          default: tx_byte = `CMD_FETCH;
        endcase
      end
      default: tx_byte = {5'h00, page_ff};
    endcase
    if (op_ff == `OP_RECALL || op_ff == `OP_FETCH)
      tx_len = 2'h3;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st_ff <= S_IDLE;
      op_ff <= `OP_CONV_T;
      page_ff <= 3'h0;
      tx_idx_ff <= 2'h0;
      bit_ff <= 3'h0;
      sh_ff <= 8'h00;
      rx_cnt_ff <= 4'h0;
      go_ff <= 1'b0;
      kind_ff <= K_RESET;
      busy_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      byte_valid_ff <= 1'b0;
      byte_data_ff <= 8'h00;
      byte_index_ff <= 4'h0;
      op_done_ff <= 1'b0;
      no_presence_ff <= 1'b0;
      line_out_ff <= 1'b0;
      line_oe_ff <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      byte_valid_ff <= 1'b0;
      op_done_ff <= 1'b0;
      line_oe_ff <= slot_oe;
      line_out_ff <= 1'b0;
      cmd_ready_ff <= (st_ff == S_IDLE) && !busy_ff && !(cmd_valid && cmd_ready_ff);
      case (st_ff)
        S_IDLE: begin
          if (cmd_valid && cmd_ready_ff) begin
            op_ff <= cmd_op;
            page_ff <= cmd_page;
            cmd_ready_ff <= 1'b0;
            st_ff <= S_RESET;
            kind_ff <= K_RESET;
            go_ff <= 1'b1;
            busy_ff <= 1'b1;
          end
        end
        S_RESET: begin
          if (slot_done) begin
            no_presence_ff <= ~slot_bit;
            tx_idx_ff <= 2'h0;
            bit_ff <= 3'h0;
            sh_ff <= `CMD_SKIP;
            if (slot_bit) begin
              st_ff <= S_TX;
              kind_ff <= K_WRITE;
              go_ff <= 1'b1;
            end else
              st_ff <= S_END;
          end
        end
        S_TX: begin
          if (slot_done) begin
            sh_ff <= {1'b0, sh_ff[7:1]};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              if (tx_idx_ff + 2'h1 == tx_len) begin
                bit_ff <= 3'h0;
                sh_ff <= 8'h00;
                rx_cnt_ff <= 4'h0;
                kind_ff <= K_READ;
                go_ff <= (op_ff != `OP_RECALL);
                if (op_ff == `OP_FETCH)
                  st_ff <= S_RX;
                else if (op_ff == `OP_RECALL)
                  st_ff <= S_END;
                else
                  st_ff <= S_POLL;
              end else begin
                tx_idx_ff <= tx_idx_ff + 2'h1;
                go_ff <= 1'b1;
              end
            end else
              go_ff <= 1'b1;
          end
          if (slot_done && bit_ff == 3'h7 && tx_idx_ff + 2'h1 != tx_len)
            sh_ff <= tx_byte;
        end
        S_RX: begin
          if (slot_done) begin
            sh_ff <= {slot_bit, sh_ff[7:1]};
            bit_ff <= bit_ff + 3'h1;
            go_ff <= 1'b1;
            if (bit_ff == 3'h7) begin
              byte_valid_ff <= 1'b1;
              byte_data_ff <= {slot_bit, sh_ff[7:1]};
              byte_index_ff <= rx_cnt_ff;
              rx_cnt_ff <= rx_cnt_ff + 4'h1;
              if (rx_cnt_ff == `PAGE_BYTES - 4'h1) begin
                go_ff <= 1'b0;
                st_ff <= S_END;
              end
            end
          end
        end
        S_POLL: begin
          if (slot_done) begin
            if (slot_bit)
              st_ff <= S_END;
            else
              go_ff <= 1'b1;
          end
        end
        S_END: begin
          op_done_ff <= 1'b1;
          busy_ff <= 1'b0;
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/swire_master_asserts.sv
// assertion checker on the single-wire bus master ports
`timescale 1ns/1ps
`default_nettype none
module swire_master_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // command and results
  input wire logic cmd_valid,
  input wire logic cmd_ready_ff,
  input wire logic byte_valid_ff,
  input wire logic [3:0] byte_index_ff,
  input wire logic op_done_ff,
  // line
  input wire logic line_out_ff,
  input wire logic line_oe_ff
);
  logic [16:0] low_ff, high_ff, gap_ff;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      low_ff <= 17'h0;
      high_ff <= 17'h1FFFF;
      gap_ff <= 17'h1FFFF;
    end else begin
      low_ff <= line_oe_ff ? low_ff + 17'h1 : 17'h0;
      high_ff <= line_oe_ff ? 17'h0 : high_ff + {16'h0, ~&high_ff};
      gap_ff <= (line_oe_ff && low_ff == 17'h0) ? 17'h1 : gap_ff + {16'h0, ~&gap_ff};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence take_s;
    cmd_valid && cmd_ready_ff;
  endsequence
  sequence drive_s;
    line_oe_ff [*8];
  endsequence
  low_time_a:
    assert property ($fell(line_oe_ff) |-> low_ff <= 17'h5DC || low_ff >= 17'hBB80
      || (low_ff >= 17'h1770 && low_ff <= 17'h2EE0)) else $error("bad low time");
  line_recovery_a:
    assert property ($rose(line_oe_ff) |-> high_ff >= 17'h64) else $error("short recovery");
  slot_gap_a:
    assert property ($rose(line_oe_ff) |-> gap_ff >= 17'h17D4) else $error("short slot");
  reset_first_a:
    assert property (take_s |-> ##[1:4] drive_s) else $error("no reset pulse");
  take_busy_a:
    assert property (take_s |=> !cmd_ready_ff) else $error("ready after take");
  done_pulse_a:
    assert property (op_done_ff |=> !op_done_ff ##[0:2] cmd_ready_ff) else $error("bad done");
  byte_pulse_a:
    assert property (byte_valid_ff |-> byte_index_ff <= 4'h8 ##1 !byte_valid_ff)
    else $error("bad byte");
  open_drain_a:
    assert property (line_out_ff == 1'b0) else $error("line driven high");
endmodule
`default_nettype wire

// ===== verif/swire_device.sv
// behavioural single-wire device answering the bus master
`timescale 1ns/1ps
`default_nettype none
module swire_device #(parameter int POLLS = 3) (
  // wire
  input wire logic line,
  output logic pull,
  // bench control
  input wire logic absent
);
  logic [7:0] fn, pg, rc;
  bit rst_seen;
  int polls;
  realtime tf;
  task automatic rx(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge line);
      #30000 v[i] = line;
      wait (line === 1'b1);
    end
  endtask
  task automatic tx(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge line);
      pull = ~v[i];
      #25000 pull = 1'b0;
    end
  endtask
  ////////////////////////////////////////
  always @(negedge line) tf = $realtime;
  always @(posedge line) if (!pull && $realtime - tf >= 479000) begin
    disable xact;
    pull = 1'b0;
    rst_seen = 1'b1;
  end
  initial begin
    pull = 1'b0;
    rc = 8'hFF;
    rst_seen = 1'b0;
    forever begin
      wait (rst_seen);
      rst_seen = 1'b0;
      begin : xact
        polls = 0;
        if (absent) wait (1'b0);
        #30000 pull = 1'b1;
        #120000 pull = 1'b0;
        rx(fn);
        wait (fn === 8'hCC);
        rx(fn);
        case (fn)
          8'h44, 8'hB4: forever begin
            tx({7'h0, polls >= POLLS}, 1);
            polls++;
          end
          8'hB8: begin
            rx(pg);
            rc = pg;
          end
          8'hBE: begin
            rx(pg);
            for (int k = 0; k < 8; k++) tx(pg === rc ? {pg[3:0], 4'(k)} : 8'hFF, 8);
            tx(8'h5A, 8);
            forever tx(8'hFF, 8);
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/swire_master_test.sv
// self-checking bench for the single-wire bus master
`timescale 1ns/1ps
`default_nettype none
module swire_master_test;
  logic sys_clk, rst_n, cmd_valid, absent;
  logic [1:0] cmd_op;
  logic [2:0] cmd_page;
  logic [7:0] got [0:15];
  wire cmd_ready_ff, byte_valid_ff, op_done_ff, no_presence_ff, line_out_ff, line_oe_ff, pull;
  wire [7:0] byte_data_ff;
  wire [3:0] byte_index_ff;
  wire line = !(line_oe_ff | pull);
  int mismatches, compares, nbytes;
  swire_master swire_master_i (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_page(cmd_page), .cmd_ready_ff(cmd_ready_ff),
    .byte_valid_ff(byte_valid_ff), .byte_data_ff(byte_data_ff), .byte_index_ff(byte_index_ff),
    .op_done_ff(op_done_ff), .no_presence_ff(no_presence_ff), .line_in(line),
    .line_out_ff(line_out_ff), .line_oe_ff(line_oe_ff));
  swire_device swire_device_i (.line(line), .pull(pull), .absent(absent));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run_op(input logic [1:0] op, input logic [2:0] pg);
    int n;
    n = 0;
    nbytes = 0;
    cmd_op = op;
    cmd_page = pg;
    cmd_valid = 1'b1;
    while (cmd_ready_ff !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (cmd_ready_ff !== 1'b1) begin
      mismatches++;
      $display("BAD %0t no ready", $time);
      test_done;
    end
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    while (op_done_ff !== 1'b1 && n < 1000000) begin
      if (byte_valid_ff === 1'b1) begin
        got[nbytes[3:0]] = byte_data_ff;
        check({4'h0, byte_index_ff}, nbytes[7:0]);
        nbytes++;
      end
      @(posedge sys_clk);
      #1 n++;
    end
    if (op_done_ff !== 1'b1) begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      test_done;
    end
  endtask
  ////////////////////////////////////////
  task automatic conv_temp;
    run_op(2'h0, 3'h0);
    check(swire_device_i.fn, 8'h44);
    check(8'(swire_device_i.polls), 8'h04);
    check({7'h0, no_presence_ff}, 8'h00);
  endtask
  task automatic conv_volt;
    run_op(2'h1, 3'h0);
    check(swire_device_i.fn, 8'hB4);
    check(8'(swire_device_i.polls), 8'h04);
    check({7'h0, no_presence_ff}, 8'h00);
  endtask
  task automatic recall_page;
    run_op(2'h2, 3'h1);
    check(swire_device_i.fn, 8'hB8);
    check(swire_device_i.rc, 8'h01);
  endtask
  task automatic fetch_page;
    run_op(2'h3, 3'h1);
    check(8'(nbytes), 8'h09);
    for (int k = 0; k < 8; k++) check(got[k], {4'h1, 4'(k)});
    check(got[8], 8'h5A);
  endtask
  task automatic no_device;
    absent = 1'b1;
    run_op(2'h0, 3'h0);
    check({7'h0, no_presence_ff}, 8'h01);
  endtask
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_page = 3'h0;
    absent = 1'b0;
    mismatches = 0;
    compares = 0;
    nbytes = 0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
    #1 conv_temp;
    conv_volt;
    recall_page;
    fetch_page;
    no_device;
    test_done;
  end
endmodule
bind swire_master swire_master_asserts swire_master_asserts_i (.sys_clk(sys_clk),
  .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready_ff(cmd_ready_ff),
  .byte_valid_ff(byte_valid_ff), .byte_index_ff(byte_index_ff), .op_done_ff(op_done_ff),
  .line_out_ff(line_out_ff), .line_oe_ff(line_oe_ff));
`default_nettype wire
